/* hw/cmpoc_top.sv */
// Comparator output conditioner: polarity, window, sampler/filter, flags.
// Assumes an AHB-Lite master, and compare, window and strobe inputs that
// are synchronous to I_MCLK; the strobe is still synchronised for safety.
//
// Function
// - Invert raw compare first when flip set.
// - Window disabled: result bypasses window stage.
// - Window on: capture each clock while window high.
// - Agree count one: filter is plain sampler.
// - Larger count: change after that many agreeing samples.
// - External strobe: sample on strobe rising edges.
// - Otherwise sample on divided peripheral clock tick.
// - Filter output resynchronised, one extra clock.
// - Rise flag on rising, fall flag on falling.
// - Interrupt follows rise and fall enables.
// - Final result readable in status bit.
// - Continuous mode bypasses window and filter.
// - Continuous: final equals gated, tracks comparator.
// - Disabled: raw compare reads as zero.
// - Sampled mode latches gated result on ticks.
// - Windowed mode: gated result drives final directly.
// - Windowed resampled: gated result resampled per tick.
// - Windowed filtered: gated result resampled and filtered.
// - Strobe off, count zero resets filter.
// - Pad select picks filtered or unfiltered result.
// - Gated result holds while window low.
// - Filter output starts zero until filled.
// - Window plus filter latency stays bounded.
`timescale 1ns/1ps
`include "cmpoc_defines.svh"

module cmpoc_top #(
   parameter int AGREE_W = 3,  // Width of the agree count field.
   parameter int DIV_W   = 8   // Width of the tick divider field.
) (
   input  wire logic        I_MCLK,
   input  wire logic        I_RST,
   input  wire logic        I_HSEL,
   input  wire logic [11:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   output logic      [31:0] O_HRDATA,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   input  wire logic        I_RAW_CMP,
   input  wire logic        I_WINDOW,
   input  wire logic        I_SAMPLE,
   output logic             O_PAD,
   output logic             O_IRQ
);

   // The packed control struct fixes the field widths.
   if (AGREE_W != 3 || DIV_W != 8)
   begin : g_bad_width
      $error("cmpoc_top: AGREE_W must be 3 and DIV_W must be 8.");
   end

   cmpoc_pkg::cmpoc_ctrl_t ctrl_q;       // Control register.
   cmpoc_pkg::cmpoc_stat_t stat_q;       // Enables and sticky flags.
   logic                   wr_pend_q;    // Write data phase pending.
   logic [11:0]            wr_addr_q;    // Address of pending write.
   logic                   raw_compare;  // Raw result after inversion.
   logic                   gated_q;      // Windowed capture register.
   logic                   gated_result; // Output of window stage.
   logic                   filt_on;      // Filter stage in use.
   logic                   smp_s1_q;     // Strobe synchroniser stage one.
   logic                   smp_s2_q;     // Strobe synchroniser stage two.
   logic                   smp_s3_q;     // Delayed copy for edge detect.
   logic [DIV_W-1:0]       tick_cnt_q;   // Internal tick down-counter.
   logic                   tick;         // Internal sampling tick.
   logic                   strobe;       // Selected sampling strobe.
   logic [AGREE_W-1:0]     run_q;        // Successive disagreeing samples.
   logic                   filt_out_q;   // Filter stage output.
   logic                   filt_sync_q;  // Filter output, resynchronised.
   logic                   final_result; // Final conditioned result.
   logic                   final_prev_q; // Final result one clock ago.
   logic                   rise_evt;     // Rising edge of final result.
   logic                   fall_evt;     // Falling edge of final result.
   logic                   addr_ok;      // Valid address phase this clock.
   logic                   clr_rise;     // Software clears the rise flag.
   logic                   clr_fall;     // Software clears the fall flag.

   // A non-idle transfer to this slave is taken when the bus is ready.
   assign addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;

   // Write data arrives one clock after the address, so remember it.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end
      else
      begin
         wr_pend_q <= addr_ok && I_HWRITE;
         wr_addr_q <= I_HADDR;
      end
   end

   // Control register write; unmapped addresses are simply ignored.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         // The reset word is wider than the struct; keep its low bits.
         ctrl_q <= cmpoc_pkg::cmpoc_ctrl_t'(`CMPOC_CTRL_RST);
      end
      else if (wr_pend_q && wr_addr_q == `CMPOC_CTRL_OFS)
      begin
         ctrl_q.enable           <= I_HWDATA[`CMPOC_CTRL_EN];
         ctrl_q.polarity_flip    <= I_HWDATA[`CMPOC_CTRL_FLIP];
         ctrl_q.window_on        <= I_HWDATA[`CMPOC_CTRL_WIN];
         ctrl_q.ext_strobe_on    <= I_HWDATA[`CMPOC_CTRL_EXT];
         ctrl_q.pad_drive_select <= I_HWDATA[`CMPOC_CTRL_PAD];
         ctrl_q.agree_count      <=
            I_HWDATA[`CMPOC_CTRL_AGR_LO +: AGREE_W];
         ctrl_q.tick_divider     <=
            I_HWDATA[`CMPOC_CTRL_DIV_LO +: DIV_W];
      end
   end

   // Read data is latched in the address phase so it comes from a flop.
   // The slave never stalls and always answers OKAY.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         O_HRDATA    <= 32'h0000_0000;
         O_HREADYOUT <= 1'b1;
         O_HRESP     <= 1'b0;
      end
      else
      begin
         O_HREADYOUT <= 1'b1;
         O_HRESP     <= 1'b0;
         if (addr_ok && !I_HWRITE)
         begin
            O_HRDATA <= 32'h0000_0000;
            if (I_HADDR == `CMPOC_CTRL_OFS)
            begin
               O_HRDATA[`CMPOC_CTRL_EN]   <= ctrl_q.enable;
               O_HRDATA[`CMPOC_CTRL_FLIP] <= ctrl_q.polarity_flip;
               O_HRDATA[`CMPOC_CTRL_WIN]  <= ctrl_q.window_on;
               O_HRDATA[`CMPOC_CTRL_EXT]  <= ctrl_q.ext_strobe_on;
               O_HRDATA[`CMPOC_CTRL_PAD]  <= ctrl_q.pad_drive_select;
               O_HRDATA[`CMPOC_CTRL_AGR_LO +: AGREE_W] <=
                  ctrl_q.agree_count;
               O_HRDATA[`CMPOC_CTRL_DIV_LO +: DIV_W] <=
                  ctrl_q.tick_divider;
            end
            else if (I_HADDR == `CMPOC_STAT_OFS)
            begin
               O_HRDATA[`CMPOC_STAT_FINAL] <= final_result;
               O_HRDATA[`CMPOC_STAT_RISE]  <= stat_q.rise_flag;
               O_HRDATA[`CMPOC_STAT_FALL]  <= stat_q.fall_flag;
               O_HRDATA[`CMPOC_STAT_RIE]   <= stat_q.rise_irq_on;
               O_HRDATA[`CMPOC_STAT_FIE]   <= stat_q.fall_irq_on;
            end
         end
      end
   end

   // Disabled gives a constant zero; otherwise flip before anything else.
   assign raw_compare = ctrl_q.enable ?
                        (I_RAW_CMP ^ ctrl_q.polarity_flip)
                        : 1'b0;

   // Window capture: sample each clock while the window is high and
   // hold the last value while it is low.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         gated_q <= 1'b0;
      end
      else if (ctrl_q.window_on && I_WINDOW)
      begin
         gated_q <= raw_compare;
      end
      // Otherwise the capture holds its value.
   end

   // With the window off the stage is bypassed entirely.
   assign gated_result = ctrl_q.window_on ? gated_q : raw_compare;

   // Filter is in use for a strobe, or for a nonzero count and divider.
   // Anything else is continuous or windowed mode, which bypasses it.
   assign filt_on = ctrl_q.enable &&
                    (ctrl_q.ext_strobe_on ||
                     (ctrl_q.agree_count != '0 &&
                      ctrl_q.tick_divider != '0));

   // Two-flop synchroniser and a third flop for the edge; the second
   // and third stages feed the detector.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         smp_s1_q <= 1'b0;
         smp_s2_q <= 1'b0;
         smp_s3_q <= 1'b0;
      end
      else
      begin
         smp_s1_q <= I_SAMPLE;
         smp_s2_q <= smp_s1_q;
         smp_s3_q <= smp_s2_q;
      end
   end

   // Down-counter reloaded from the divider; a tick on reaching zero
   // gives one pulse every divider clocks.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST || !filt_on || ctrl_q.ext_strobe_on)
      begin
         tick_cnt_q <= '0;
      end
      else if (tick)
      begin
         tick_cnt_q <= ctrl_q.tick_divider - 8'h01;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q - 8'h01;
      end
   end

   assign tick = (tick_cnt_q == '0);

   // Strobe source follows the strobe control. Window and strobe are
   // assumed never to be set together; the window then still gates the strobed samples.
   assign strobe = ctrl_q.ext_strobe_on ? (smp_s2_q && !smp_s3_q)
                                        : tick;

   // Agreement filter: the output moves only after agree_count successive
   // samples disagree with it. A count of one makes it a sampler. It is
   // held at zero while unused, which is also the software reset path.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST || !filt_on)
      begin
         run_q      <= '0;
         filt_out_q <= 1'b0;
      end
      else if (strobe)
      begin
         if (gated_result == filt_out_q)
         begin
            run_q <= '0;
         end
         else if (run_q + 3'h1 >= ctrl_q.agree_count)
         begin
            run_q      <= '0;
            filt_out_q <= gated_result;
         end
         else
         begin
            run_q <= run_q + 3'h1;
         end
      end
   end

   // The filter output is retimed once more, costing one clock.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST || !filt_on)
      begin
         filt_sync_q <= 1'b0;
      end
      else
      begin
         filt_sync_q <= filt_out_q;
      end
   end

   // Without the filter the final result follows the gated result
   // combinationally, so status reads track the comparator.
   assign final_result = filt_on ? filt_sync_q : gated_result;

   // Edge detection on the final result.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         final_prev_q <= 1'b0;
      end
      else
      begin
         final_prev_q <= final_result;
      end
   end

   assign rise_evt = final_result && !final_prev_q;
   assign fall_evt = !final_result && final_prev_q;
   assign clr_rise = wr_pend_q && wr_addr_q == `CMPOC_STAT_OFS &&
                     I_HWDATA[`CMPOC_STAT_RISE];
   assign clr_fall = wr_pend_q && wr_addr_q == `CMPOC_STAT_OFS &&
                     I_HWDATA[`CMPOC_STAT_FALL];

   // Flags clear on writing one; a new edge in the same clock wins so
   // that no event is lost.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         stat_q <= '0;
      end
      else
      begin
         stat_q.rise_flag <= rise_evt ||
                             (stat_q.rise_flag && !clr_rise);
         stat_q.fall_flag <= fall_evt ||
                             (stat_q.fall_flag && !clr_fall);
         if (wr_pend_q && wr_addr_q == `CMPOC_STAT_OFS)
         begin
            stat_q.rise_irq_on <= I_HWDATA[`CMPOC_STAT_RIE];
            stat_q.fall_irq_on <= I_HWDATA[`CMPOC_STAT_FIE];
         end
      end
   end

   // Interrupt level is the enabled sticky flags, from a flop.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         O_IRQ <= 1'b0;
      end
      else
      begin
         O_IRQ <= (stat_q.rise_flag && stat_q.rise_irq_on) ||
                  (stat_q.fall_flag && stat_q.fall_irq_on);
      end
   end

   // Pad shows the final or the raw result; the flop adds one clock,
   // which a fault path through this pin must tolerate.
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         O_PAD <= 1'b0;
      end
      else
      begin
         O_PAD <= ctrl_q.pad_drive_select ? final_result
                                          : raw_compare;
      end
   end

   // Checks on the signal path, the edge flags and the interrupt.
   a_disabled_zero: assert property (@(posedge I_MCLK) disable iff (I_RST)
      !ctrl_q.enable |-> !raw_compare)
      else $error("raw result not zero while disabled");

   a_flip_applied: assert property (@(posedge I_MCLK) disable iff (I_RST)
      ctrl_q.enable |-> raw_compare == (I_RAW_CMP ^ ctrl_q.polarity_flip))
      else $error("polarity flip not applied");

   a_window_hold: assert property (@(posedge I_MCLK) disable iff (I_RST)
      ctrl_q.window_on && !I_WINDOW |=> $stable(gated_q))
      else $error("gated result moved while window low");

   a_window_take: assert property (@(posedge I_MCLK) disable iff (I_RST)
      ctrl_q.window_on && I_WINDOW |=> gated_q == $past(raw_compare))
      else $error("gated result missed window capture");

   a_window_bypass: assert property (@(posedge I_MCLK) disable iff (I_RST)
      !ctrl_q.window_on && !filt_on |-> final_result == raw_compare)
      else $error("continuous mode not bypassed");

   a_filter_reset: assert property (@(posedge I_MCLK) disable iff (I_RST)
      !ctrl_q.ext_strobe_on && ctrl_q.agree_count == '0
      |=> !filt_out_q && !final_result || !filt_on)
      else $error("filter not cleared by reset setting");

   a_sampler_take: assert property (@(posedge I_MCLK) disable iff (I_RST)
      filt_on && ctrl_q.agree_count == 3'h1 && strobe
      ##1 filt_on |-> filt_out_q == $past(gated_result) ##1
      final_result == $past(filt_out_q) || !filt_on)
      else $error("sampler output wrong");

   a_tick_spacing: assert property (@(posedge I_MCLK) disable iff (I_RST)
      filt_on && !ctrl_q.ext_strobe_on && ctrl_q.tick_divider == 8'h02
      && tick ##1 $stable(ctrl_q) |-> !tick ##1 (tick || !$stable(ctrl_q)))
      else $error("internal tick spacing wrong");

   a_rise_flag: assert property (@(posedge I_MCLK) disable iff (I_RST)
      rise_evt |=> stat_q.rise_flag ##1 (O_IRQ || !$past(stat_q.rise_irq_on)))
      else $error("rising edge lost or interrupt missing");

   a_irq_gate: assert property (@(posedge I_MCLK) disable iff (I_RST)
      !stat_q.rise_flag && !stat_q.fall_flag |=> !O_IRQ)
      else $error("interrupt raised without a flag");

endmodule // cmpoc_top

/* hw/cmpoc_defines.svh */
// Offsets, field positions and reset values of the comparator conditioner.
// Assumes a 32-bit AHB-Lite register space with one word per register.
`ifndef CMPOC_DEFINES_SVH
`define CMPOC_DEFINES_SVH

// Byte addresses of the two registers.
`define CMPOC_CTRL_OFS      12'h000
`define CMPOC_STAT_OFS      12'h004

// Field positions in the control register.
`define CMPOC_CTRL_EN       0
`define CMPOC_CTRL_FLIP     1
`define CMPOC_CTRL_WIN      2
`define CMPOC_CTRL_EXT      3
`define CMPOC_CTRL_PAD      4
`define CMPOC_CTRL_AGR_LO   8
`define CMPOC_CTRL_DIV_LO   16

// Field positions in the status register.
`define CMPOC_STAT_FINAL    0
`define CMPOC_STAT_RISE     1
`define CMPOC_STAT_FALL     2
`define CMPOC_STAT_RIE      3
`define CMPOC_STAT_FIE      4

// Reset value of every control field.
`define CMPOC_CTRL_RST      32'h0000_0000

`endif

/* hw/cmpoc_pkg.sv */
// Types shared by the comparator output conditioner.
// Assumes the field widths below match the module parameters' defaults.
package cmpoc_pkg;

   // Software control fields that steer the signal path.
   typedef struct packed
   {
      logic [7:0] tick_divider;   // Sampling tick period in clocks.
      logic [2:0] agree_count;    // Successive samples that must agree.
      logic       pad_drive_select; // Pad shows filtered result when 1.
      logic       ext_strobe_on;  // Sample on external strobe edges.
      logic       window_on;      // Gate the result with the window input.
      logic       polarity_flip;  // Invert the raw compare result.
      logic       enable;         // Block enable.
   } cmpoc_ctrl_t;

   // Interrupt enables and sticky edge flags.
   typedef struct packed
   {
      logic rise_irq_on;          // Rising edge raises the interrupt.
      logic fall_irq_on;          // Falling edge raises the interrupt.
      logic rise_flag;            // Sticky rising edge flag.
      logic fall_flag;            // Sticky falling edge flag.
   } cmpoc_stat_t;

endpackage

/* verif/cmpoc_partner.sv */
// Partner model: comparator core and PWM window and strobe source.
// Assumes the bench sets the level and patterns between clock edges.
`timescale 1ns/1ps

module cmpoc_partner (
   input  wire logic       i_mclk,
   input  wire logic       i_level,   // Level the comparator reports.
   input  wire logic       i_win_pwm, // Window pulses when 1.
   input  wire logic       i_win_lvl, // Window level when not pulsing.
   input  wire logic [3:0] i_smp_per, // Strobe period, 0 stops it.
   output logic            o_raw_cmp = 1'b0,
   output logic            o_window  = 1'b0,
   output logic            o_sample  = 1'b0
);
   logic [2:0] win_cnt_q = 3'h0; // Window phase.
   logic [3:0] smp_cnt_q = 4'h0; // Strobe phase.

   // The comparator answers one clock after the level moves.
   always_ff @(posedge i_mclk) o_raw_cmp <= i_level;

   // Window is high four clocks of eight, like a PWM gate.
   always_ff @(posedge i_mclk)
   begin
      win_cnt_q <= win_cnt_q + 3'h1;
      o_window  <= i_win_pwm ? (win_cnt_q < 3'h4) : i_win_lvl;
   end

   // Strobe is high two clocks so that no synchroniser misses it.
   always_ff @(posedge i_mclk)
   begin
      smp_cnt_q <= (smp_cnt_q + 4'h1 >= i_smp_per) ? 4'h0 : smp_cnt_q + 4'h1;
      o_sample  <= (i_smp_per != 4'h0) && (smp_cnt_q < 4'h2);
   end
endmodule // cmpoc_partner

/* verif/test_comparator_output_conditioner.sv */
// Self-checking bench for the comparator output conditioner.
// Assumes the partner model feeds compare, window and strobe inputs.
`timescale 1ns/1ps
`include "cmpoc_defines.svh"

module test_comparator_output_conditioner;
   logic        I_MCLK   = 1'b0;
   logic        I_RST    = 1'b1;
   logic        I_HSEL   = 1'b0;
   logic [11:0] I_HADDR  = 12'h000;
   logic [1:0]  I_HTRANS = 2'h0;
   logic        I_HWRITE = 1'b0;
   logic [2:0]  I_HSIZE  = 3'h2;
   logic [31:0] I_HWDATA = 32'h0;
   logic        I_HREADY, O_HREADYOUT, O_HRESP, O_PAD, O_IRQ;
   logic [31:0] O_HRDATA;
   logic        I_RAW_CMP, I_WINDOW, I_SAMPLE;
   logic        level = 1'b0;     // Level the comparator is to report.
   logic        win_pwm = 1'b1;   // Window pulses unless held.
   logic [31:0] ctrl_m = 32'h0;   // Model of the control word.
   logic        g_q = 1'b0;       // Model of the window latch.
   logic        raw_m, gated_m, pad_m;
   logic [31:0] rd, modes [11], tmg [3];
   int          n_errors = 0, cmp_count = 0, cycles = 0, seed = 30;
   int          n, lim, ag, lo;

   assign I_HREADY = O_HREADYOUT;
   cmpoc_top cmpoc_top_i (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_HSEL(I_HSEL),
      .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
      .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
      .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
      .I_RAW_CMP(I_RAW_CMP), .I_WINDOW(I_WINDOW), .I_SAMPLE(I_SAMPLE),
      .O_PAD(O_PAD), .O_IRQ(O_IRQ));
   cmpoc_partner cmpoc_partner_i (.i_mclk(I_MCLK), .i_level(level),
      .i_win_pwm(win_pwm), .i_win_lvl(1'b0), .i_smp_per(4'h7),
      .o_raw_cmp(I_RAW_CMP), .o_window(I_WINDOW), .o_sample(I_SAMPLE));

   // Settled model: only compared once every filter has had time to fill.
   assign raw_m   = ctrl_m[`CMPOC_CTRL_EN] & (I_RAW_CMP ^ ctrl_m[1]);
   assign gated_m = ctrl_m[`CMPOC_CTRL_WIN] ? g_q : raw_m;
   assign pad_m   = ctrl_m[`CMPOC_CTRL_PAD] ? gated_m : raw_m;
   always @(posedge I_MCLK) if (I_WINDOW === 1'b1) g_q <= raw_m;

   always #5 I_MCLK = ~I_MCLK;

   // A hang is cut short well beyond the few thousand cycles needed.
   always @(posedge I_MCLK)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         n_errors = n_errors + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("wrong value at %0t: seen %h, expected %h",
                  $time, seen, exp);
      end
   endtask

   // One single AHB-Lite transfer; the request stands until hready is seen.
   task automatic ahb(input logic wr_en, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge I_MCLK);
      I_HSEL   <= 1'b1;
      I_HTRANS <= 2'h2;
      I_HADDR  <= a;
      I_HWRITE <= wr_en;
      do @(posedge I_MCLK); while (O_HREADYOUT !== 1'b1);
      I_HTRANS <= 2'h0;
      I_HWDATA <= wd;
      do @(posedge I_MCLK); while (O_HREADYOUT !== 1'b1);
      rd = O_HRDATA;
      chk({31'h0, O_HRESP}, 32'h0);
      chk({31'h0, O_HREADYOUT}, 32'h1);
      if (wr_en && a == `CMPOC_CTRL_OFS)
         ctrl_m = wd;
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge I_MCLK);
   endtask

   function automatic logic [31:0] mk(input int en, fl, wi, ex, pd, ag, dv);
      mk = {8'h0, dv[7:0], 5'h0, ag[2:0], 3'h0, pd[0], ex[0], wi[0], fl[0],
            en[0]};
   endfunction

   initial
   begin
      // Legal combinations only, never window with strobe.
      modes[0]  = mk(0, 0, 0, 0, 0, 0, 0);
      modes[1]  = mk(1, 0, 0, 0, 0, 0, 5);
      modes[2]  = mk(1, 0, 0, 0, 0, 3, 0);
      modes[3]  = mk(1, 0, 0, 1, 0, 1, 0);
      modes[4]  = mk(1, 0, 0, 0, 0, 1, 3);
      modes[5]  = mk(1, 0, 0, 1, 0, 3, 0);
      modes[6]  = mk(1, 0, 0, 0, 0, 2, 4);
      modes[7]  = mk(1, 0, 1, 0, 0, 0, 9);
      modes[8]  = mk(1, 0, 1, 0, 0, 4, 0);
      modes[9]  = mk(1, 0, 1, 0, 0, 1, 2);
      modes[10] = mk(1, 0, 1, 0, 0, 3, 2);
      tmg[0] = mk(1, 0, 0, 0, 1, 3, 4);
      tmg[1] = mk(1, 0, 0, 0, 1, 1, 3);
      tmg[2] = mk(1, 0, 0, 1, 1, 2, 0);
      repeat (3) @(posedge I_MCLK);
      I_RST <= 1'b0;
      // Reset values, then an unmapped place that reads zero and ignores.
      ahb(1'b0, `CMPOC_CTRL_OFS, 32'h0);
      chk(rd, `CMPOC_CTRL_RST);
      ahb(1'b0, `CMPOC_STAT_OFS, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, 12'h008, 32'hffff_ffff);
      ahb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b0, `CMPOC_CTRL_OFS, 32'h0);
      chk(rd, `CMPOC_CTRL_RST);
      // Every mode with random levels; flip alternates, pad select changes every second mode.
      for (int i = 0; i < 11; i++)
      begin
         ahb(1'b1, `CMPOC_CTRL_OFS, 32'h0);
         ahb(1'b1, `CMPOC_CTRL_OFS, modes[i] | mk(0, i % 2, 0, 0, i / 2 % 2,
             0, 0));
         for (int k = 0; k < 3; k++)
         begin
            @(posedge I_MCLK);
            n = $random(seed);
            level <= n[0];
            cyc(60);
            @(negedge I_MCLK);
            chk(O_PAD, pad_m);
            ahb(1'b0, `CMPOC_STAT_OFS, 32'h0);
            chk(rd[0], gated_m);
         end
      end
      // A low window holds the latched value while the comparator moves.
      ahb(1'b1, `CMPOC_CTRL_OFS, 32'h0);
      ahb(1'b1, `CMPOC_CTRL_OFS, mk(1, 0, 1, 0, 1, 0, 0));
      level <= 1'b1;
      cyc(30);
      win_pwm <= 1'b0;
      cyc(4);
      level <= 1'b0;
      cyc(10);
      @(negedge I_MCLK);
      chk(O_PAD, 32'h1);
      ahb(1'b1, `CMPOC_CTRL_OFS, mk(1, 0, 1, 0, 0, 0, 0));
      cyc(3);
      @(negedge I_MCLK);
      chk(O_PAD, 32'h0);
      @(posedge I_MCLK);
      win_pwm <= 1'b1;
      // Filters start at zero and move only after enough agreeing samples.
      for (int i = 0; i < 3; i++)
      begin
         ahb(1'b1, `CMPOC_CTRL_OFS, 32'h0);
         level <= 1'b1;
         cyc(5);
         ahb(1'b1, `CMPOC_CTRL_OFS, tmg[i]);
         ag  = tmg[i][10:8];
         n   = (i == 2) ? 7 : int'(tmg[i][23:16]);
         lo  = (ag - 1) * n;
         lim = ag * n + ((i == 2) ? 8 : 4) - lo;
         for (int j = 0; j < lo; j++)
         begin
            @(negedge I_MCLK);
            chk(O_PAD, 32'h0);
         end
         n = 0;
         while (O_PAD !== 1'b1 && n < lim)
         begin
            @(negedge I_MCLK);
            n = n + 1;
         end
         chk(O_PAD, 32'h1);
      end
      // Edge flags, write-one-to-clear and the interrupt enables.
      ahb(1'b1, `CMPOC_CTRL_OFS, mk(1, 0, 0, 0, 1, 0, 0));
      level <= 1'b0;
      cyc(6);
      ahb(1'b1, `CMPOC_STAT_OFS, 32'h6);
      level <= 1'b1;
      cyc(6);
      ahb(1'b0, `CMPOC_STAT_OFS, 32'h0);
      chk(rd, 32'h3);
      chk(O_IRQ, 32'h0);
      ahb(1'b1, `CMPOC_STAT_OFS, 32'h8);
      cyc(3);
      @(negedge I_MCLK);
      chk(O_IRQ, 32'h1);
      @(posedge I_MCLK);
      level <= 1'b0;
      cyc(6);
      ahb(1'b0, `CMPOC_STAT_OFS, 32'h0);
      chk(rd, 32'he);
      ahb(1'b1, `CMPOC_STAT_OFS, 32'ha);
      cyc(3);
      @(negedge I_MCLK);
      chk(O_IRQ, 32'h0);
      ahb(1'b1, `CMPOC_STAT_OFS, 32'h10);
      cyc(3);
      @(negedge I_MCLK);
      chk(O_IRQ, 32'h1);
      ahb(1'b1, `CMPOC_STAT_OFS, 32'h14);
      cyc(3);
      @(negedge I_MCLK);
      chk(O_IRQ, 32'h0);
      ahb(1'b0, `CMPOC_STAT_OFS, 32'h0);
      chk(rd, 32'h10);
      report_and_stop();
   end
endmodule // test_comparator_output_conditioner
